// ===== hw/asc_top.sv
`timescale 1ns/1ps
`default_nettype none
module asc_top (
    // Bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Converter core
    input wire logic seq_done,
    input wire logic sample_done,
    output var asc_pkg::asc_cfg_t cfg,
    output logic use_mux_b,
    output logic [3:0] write_index,
    output logic conv_irq
);
    import asc_pkg::*;

    logic [15:0] ctrl_q;
    logic fill_q;
    logic alt_b_q;
    logic [3:0] seq_cnt_q;
    logic [3:0] widx_q;
    logic irq_q;
    logic wr_pend_q;
    logic [11:0] addr_q;
    logic [31:0] rdata_q;
    logic acc_ok;

    assign acc_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase captured; writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q <= 12'h000;
        end else begin
            wr_pend_q <= acc_ok && hwrite;
            addr_q <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= ASC_CTRL2_RST;
        end else if (wr_pend_q && addr_q == ASC_CTRL2_OFS) begin
            ctrl_q <= hwdata[15:0] & ASC_WR_MASK & ~(16'h0001 << ASC_FILL_BIT);
        end
    end

    // Read data registered in the address phase, zero for unmapped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (acc_ok && !hwrite) begin
            case (haddr)
                ASC_CTRL2_OFS: rdata_q <= {16'h0000, ctrl_q | (16'(fill_q) << ASC_FILL_BIT)};
                ASC_STATUS_OFS: rdata_q <= {23'h0, widx_q, seq_cnt_q, alt_b_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign hrdata = rdata_q;

    // only codes 001..011 pick external pins
    always_comb begin
        cfg.refs.pos_external = !ctrl_q[ASC_REF_LSB+2] && ctrl_q[ASC_REF_LSB];
        cfg.refs.neg_external = !ctrl_q[ASC_REF_LSB+2] && ctrl_q[ASC_REF_LSB+1];
        cfg.scan_enable = ctrl_q[ASC_SCAN_BIT];
        cfg.split_mode = ctrl_q[ASC_SPLIT_BIT];
        cfg.alternate = ctrl_q[ASC_ALT_BIT];
        cfg.per_interrupt = ctrl_q[ASC_SPI_LSB +: 4];
    end

    // Mux select toggles per sample; restarts on A after each sequence
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alt_b_q <= 1'b0;
        end else if (!ctrl_q[ASC_ALT_BIT] || seq_done) begin
            alt_b_q <= 1'b0;
        end else if (sample_done) begin
            alt_b_q <= !alt_b_q;
        end
    end
    assign use_mux_b = alt_b_q;

    // Sequence counter and interrupt pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_cnt_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            irq_q <= 1'b0;
            if (seq_done) begin
                if (seq_cnt_q >= ctrl_q[ASC_SPI_LSB +: 4]) begin
                    seq_cnt_q <= 4'h0;
                    irq_q <= 1'b1;
                end else begin
                    seq_cnt_q <= seq_cnt_q + 4'h1;
                end
            end
        end
    end
    assign conv_irq = irq_q;

    // Result write pointer; split mode flips halves at each interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            widx_q <= 4'h0;
            fill_q <= 1'b0;
        end else if (irq_q) begin
            if (ctrl_q[ASC_SPLIT_BIT]) begin
                fill_q <= !fill_q;
                widx_q <= fill_q ? 4'h0 : 4'(ASC_HALF_WORDS);
            end else begin
                fill_q <= 1'b0;
                widx_q <= 4'h0;
            end
        end else if (sample_done) begin
            widx_q <= widx_q + 4'h1;
        end
    end
    assign write_index = widx_q;

    // Interrupt pacing
    a_irq_count: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_done && seq_cnt_q == ctrl_q[ASC_SPI_LSB +: 4] |=> irq_q)
        else $error("interrupt missed at terminal count");
    a_irq_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_q |-> $past(seq_done))
        else $error("interrupt without sequence");
    a_irq_early: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_done && seq_cnt_q < cfg.per_interrupt |=> !irq_q)
        else $error("interrupt before terminal count");
    a_cnt_step: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_done && seq_cnt_q < cfg.per_interrupt |=> seq_cnt_q == $past(seq_cnt_q) + 4'h1)
        else $error("sequence count did not advance");
    a_cnt_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !seq_done |=> seq_cnt_q == $past(seq_cnt_q))
        else $error("sequence count moved without a sequence");

    // Reference decode; 1xx codes fall back to the internal rails
    a_ref_int: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_q[ASC_REF_LSB+2] |-> !cfg.refs.pos_external && !cfg.refs.neg_external)
        else $error("1xx code must use internal rails");
    a_ref_none: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_q[ASC_REF_LSB +: 3] == 3'b000 |-> !cfg.refs.pos_external && !cfg.refs.neg_external)
        else $error("code 000 must use internal rails");
    a_ref_pos: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_q[ASC_REF_LSB +: 3] == 3'b001 |-> cfg.refs.pos_external && !cfg.refs.neg_external)
        else $error("code 001 must use external positive only");
    a_ref_neg: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_q[ASC_REF_LSB +: 3] == 3'b010 |-> !cfg.refs.pos_external && cfg.refs.neg_external)
        else $error("code 010 must use external negative only");
    a_ref_both: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_q[ASC_REF_LSB +: 3] == 3'b011 |-> cfg.refs.pos_external && cfg.refs.neg_external)
        else $error("code 011 must use both external references");

    // Register access; a write is checked one edge after its data phase
    a_unused_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q & 16'h1b40) == 16'h0000)
        else $error("unused bits not zero");
    a_mask_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q && addr_q == ASC_CTRL2_OFS |=> ctrl_q == ($past(hwdata[15:0]) & ASC_WR_MASK))
        else $error("control write not masked");
    a_scan_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q && addr_q == ASC_CTRL2_OFS |=> cfg.scan_enable == $past(hwdata[ASC_SCAN_BIT]))
        else $error("scan select does not follow write");
    a_read_fill: assert property (@(posedge hclk) disable iff (!hresetn)
        acc_ok && !hwrite && haddr == ASC_CTRL2_OFS |=> hrdata[ASC_FILL_BIT] == $past(fill_q))
        else $error("fill status not read back");
    a_read_unused: assert property (@(posedge hclk) disable iff (!hresetn)
        acc_ok && !hwrite && haddr == ASC_CTRL2_OFS |=> (hrdata & 32'hffff_1b40) == 32'h0)
        else $error("unused bits read as one");
    a_read_unmapped: assert property (@(posedge hclk) disable iff (!hresetn)
        acc_ok && !hwrite && haddr != ASC_CTRL2_OFS && haddr != ASC_STATUS_OFS
        |=> hrdata == 32'h0)
        else $error("unmapped read not zero");

    // Mux alternation
    a_alt_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl_q[ASC_ALT_BIT] |=> !use_mux_b)
        else $error("mux b used without alternate");
    a_alt_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg.alternate && sample_done && !seq_done |=> use_mux_b != $past(use_mux_b))
        else $error("alternate did not toggle");
    a_alt_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_done |=> !use_mux_b)
        else $error("sequence did not restart on mux a");

    // Result store halves
    a_fill_flip: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_q && ctrl_q[ASC_SPLIT_BIT] |=> fill_q != $past(fill_q))
        else $error("fill half did not flip");
    a_fill_single: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_q && !cfg.split_mode |=> !fill_q)
        else $error("fill status set in single buffer mode");
    a_half_jump: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_q && cfg.split_mode |=> write_index == (fill_q ? 4'(ASC_HALF_WORDS) : 4'h0))
        else $error("write index not at start of filling half");
    a_single_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_q && !cfg.split_mode |=> write_index == 4'h0)
        else $error("single buffer did not restart at word zero");
    a_widx_step: assert property (@(posedge hclk) disable iff (!hresetn)
        sample_done && !irq_q |=> write_index == $past(write_index) + 4'h1)
        else $error("write index did not advance");

    // Main scenarios
    c_irq: cover property (@(posedge hclk) irq_q);
    c_split_flip: cover property (@(posedge hclk) irq_q && ctrl_q[ASC_SPLIT_BIT]);
    c_mux_b: cover property (@(posedge hclk) use_mux_b);
    c_scan_on: cover property (@(posedge hclk) cfg.scan_enable);
    c_ref_both: cover property (@(posedge hclk) cfg.refs.pos_external && cfg.refs.neg_external);
endmodule
`default_nettype wire

// ===== common/asc_pkg.sv
// Overview of operation
// - Three-bit field picks references; 000 and 1xx internal, 001/010/011 external mixes.
// - Scan bit set steps channel 0 positive input through scan list on mux A.
// - Fill-status bit shows which half converter fills, only in split mode.
// - Conversion interrupt once every field-plus-one completed sequences.
// - Buffer-mode bit splits result store into two eight-word halves.
// - Alternate bit: first sample mux A, then alternate B and A.
// - Unused bits 12-11, 9-8 and 6 read zero, writes ignored.
package asc_pkg;
    localparam logic [11:0] ASC_CTRL2_OFS = 12'h000;
    localparam logic [11:0] ASC_STATUS_OFS = 12'h004;
    localparam logic [15:0] ASC_CTRL2_RST = 16'h0000;
    localparam logic [15:0] ASC_WR_MASK = 16'he43f;
    localparam int ASC_REF_LSB = 13;
    localparam int ASC_SCAN_BIT = 10;
    localparam int ASC_FILL_BIT = 7;
    localparam int ASC_SPI_LSB = 2;
    localparam int ASC_SPLIT_BIT = 1;
    localparam int ASC_ALT_BIT = 0;
    localparam int ASC_HALF_WORDS = 8;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    typedef struct packed {
        logic pos_external;
        logic neg_external;
    } asc_ref_t;

    typedef struct packed {
        asc_ref_t refs;
        logic scan_enable;
        logic split_mode;
        logic alternate;
        logic [3:0] per_interrupt;
    } asc_cfg_t;
endpackage

// ===== verif/asc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module asc_core_model (
    // Clock
    input wire logic hclk,
    // Core events
    output logic sample_done,
    output logic seq_done
);
    initial begin
        sample_done = 1'b0;
        seq_done = 1'b0;
    end
    // One sample per call; gap lets the core answer slowly
    task automatic step(input logic last, input int gap);
        @(posedge hclk);
        sample_done <= 1'b1;
        seq_done <= last;
        @(posedge hclk);
        sample_done <= 1'b0;
        seq_done <= 1'b0;
        repeat (gap) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

// ===== verif/adc_sequence_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_control_bench;
    import asc_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    logic [31:0] hwdata = 32'h0, hrdata, q;
    logic hreadyout, hresp, use_mux_b, conv_irq, seq_done, sample_done;
    logic [3:0] write_index;
    asc_cfg_t cfg;
    int n_checks = 0, bad_count = 0, irq_n = 0, b;
    always #5 hclk = ~hclk;
    always @(posedge hclk) if (conv_irq === 1'b1) irq_n <= irq_n + 1;
    asc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .seq_done(seq_done), .sample_done(sample_done), .cfg(cfg),
        .use_mux_b(use_mux_b), .write_index(write_index), .conv_irq(conv_irq));
    asc_core_model i_core (.hclk(hclk), .sample_done(sample_done), .seq_done(seq_done));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Read data is taken at the data-phase edge, before the slave moves on
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, ASC_CTRL2_OFS, 32'h0);
        chk(q, 32'h0);
        chk(32'(cfg), 32'h0);
        xfer(1'b1, ASC_CTRL2_OFS, 32'hffff_ffff);
        xfer(1'b0, ASC_CTRL2_OFS, 32'h0);
        chk(q, 32'h0000_e43f);
        xfer(1'b0, 12'h008, 32'h0);
        chk(q, 32'h0);
        chk(32'(hresp), 32'h0);
        $display("test reset_mask done");
        for (int r = 0; r < 8; r++) begin
            xfer(1'b1, ASC_CTRL2_OFS, 32'(r << 13) | 32'h0400);
            chk(32'(cfg.refs), 32'((r == 1) ? 2 : (r == 2) ? 1 : (r == 3) ? 3 : 0));
            chk(32'(cfg.scan_enable), 32'h1);
        end
        $display("test references done");
        // Every group ends on a whole count, so each code starts from zero
        for (int c = 0; c < 16; c += 5) begin
            xfer(1'b1, ASC_CTRL2_OFS, 32'(c << 2));
            chk(32'(cfg.per_interrupt), 32'(c));
            chk(32'(cfg.scan_enable), 32'h0);
            b = irq_n;
            repeat (2 * c + 1) i_core.step(1'b1, c % 3);
            repeat (2) @(posedge hclk);
            chk(32'(irq_n - b), 32'h1);
            // Status holds write index, sequence count and mux b flag
            xfer(1'b0, ASC_STATUS_OFS, 32'h0);
            chk(q, 32'((c << 5) | (c << 1)));
            i_core.step(1'b1, 2);
            chk(32'(irq_n - b), 32'h2);
        end
        $display("test interrupt_count done");
        xfer(1'b1, ASC_CTRL2_OFS, 32'h0002);
        chk(32'(cfg.split_mode), 32'h1);
        i_core.step(1'b1, 2);
        xfer(1'b0, ASC_CTRL2_OFS, 32'h0);
        chk(q, 32'h0082);
        chk(32'(write_index), 32'h8);
        xfer(1'b0, ASC_STATUS_OFS, 32'h0);
        chk(q, 32'h0000_0100);
        i_core.step(1'b1, 2);
        xfer(1'b0, ASC_CTRL2_OFS, 32'h0);
        chk(q, 32'h0002);
        chk(32'(write_index), 32'h0);
        $display("test split_buffer done");
        xfer(1'b1, ASC_CTRL2_OFS, 32'h0001);
        chk(32'(cfg.alternate), 32'h1);
        chk(32'(use_mux_b), 32'h0);
        i_core.step(1'b0, 1);
        chk(32'(use_mux_b), 32'h1);
        i_core.step(1'b0, 1);
        chk(32'(use_mux_b), 32'h0);
        i_core.step(1'b0, 1);
        xfer(1'b1, ASC_CTRL2_OFS, 32'h0);
        // Mux select drops one edge after the write lands
        @(posedge hclk);
        #1;
        chk(32'(use_mux_b), 32'h0);
        i_core.step(1'b0, 1);
        chk(32'(use_mux_b), 32'h0);
        $display("test alternate done");
        conclude();
    end
endmodule
`default_nettype wire
